// ==== logic/data_link_controller_scheduler.v ====
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`include "dlcs_map.vh"
`default_nettype none

// Functional notes
// RULE_01: Input queue is a 256-word hardware FIFO.
// RULE_02: Words carry 23 data bits plus parity.
// RULE_03: Bad odd parity drops word, reports error.
// RULE_04: Maintenance bit zero marks data words.
// RULE_05: Fixed 20 ms cycle restarts the sequence.
// RULE_06: Overrun cycle makes next cycle audits only.
// RULE_07: Unloading stops when empty or after 10 ms.
// RULE_08: Cumulative unload count advances per word.
// RULE_09: High priority controller orders run immediately.
// RULE_10: Parameter write restarts audits with priority.
// RULE_11: Link scan stops at 16 or under 5 ms.
// RULE_12: Next cycle scan resumes where it stopped.
// RULE_13: Under 3 ms left after links: halt.
// RULE_14: Even cycle controller slot, odd application slot.
// RULE_15: Audit first after parameter, else deferred order.
// RULE_16: Slot end sets cycle-done, then halts.
// RULE_17: Send frame only with room and data.
// RULE_18: Completed receive frame gets reply, never RNR.
// RULE_19: Load pointer advances on error-free frame.
// RULE_20: Activation resets protocol, reports restored or impasse.
// RULE_21: Soft switch waits for a clean point.
// RULE_22: Diagnostics on inactive links, 3 ms segments.
// RULE_23: Bit 22 splits application and controller orders.
// RULE_24: Stored check bit is one on good parity.
// RULE_25: Wrong message word count discards the message.
// RULE_26: 16-bit cycle counter, LSB picks slot.
module data_link_controller_scheduler #(
	parameter DEPTH       = 256,  // Input queue words
	parameter AW          = 8,    // Queue address width
	parameter NLINK       = 16,   // Links scanned per cycle
	parameter NSEG        = 4,    // Audit segments per pass
	parameter TW          = 20,   // Cycle timer width
	parameter CYCLE_CLKS  = `CYCLE_MS * `CLK_KHZ,
	parameter UNLOAD_CLKS = `UNLOAD_MS * `CLK_KHZ,
	parameter LINK_CLKS   = `LINK_MIN_MS * `CLK_KHZ,
	parameter MAINT_CLKS  = `MAINT_MIN_MS * `CLK_KHZ,
	parameter DIAG_CLKS   = `DIAG_MAX_MS * `CLK_KHZ
) (
	input  wire        aclk,          // System clock
	input  wire        aresetn,       // Synchronous reset
	input  wire [31:0] s_axi_awaddr,  // Write address
	input  wire        s_axi_awvalid, // Write address valid
	output wire        s_axi_awready, // Write address ready
	input  wire [31:0] s_axi_wdata,   // Write data
	input  wire [3:0]  s_axi_wstrb,   // Write strobes
	input  wire        s_axi_wvalid,  // Write data valid
	output wire        s_axi_wready,  // Write data ready
	output reg  [1:0]  s_axi_bresp,   // Write response
	output reg         s_axi_bvalid,  // Write response valid
	input  wire        s_axi_bready,  // Write response ready
	input  wire [31:0] s_axi_araddr,  // Read address
	input  wire        s_axi_arvalid, // Read address valid
	output wire        s_axi_arready, // Read address ready
	output reg  [31:0] s_axi_rdata,   // Read data
	output reg  [1:0]  s_axi_rresp,   // Read response
	output reg         s_axi_rvalid,  // Read data valid
	input  wire        s_axi_rready,  // Read data ready
	input  wire [23:0] in_word,       // Host word, bit 23 parity
	input  wire        in_valid,      // Host word offered
	output wire        in_ready,      // Queue has room
	output reg  [15:0] data_payload,  // Data word low bytes
	output reg  [7:0]  data_dest,     // Destination number
	output reg         data_valid,    // Data word pulse
	output reg         msg_discard,   // Drop open message; on a heading data_dest already shows the new one
	output reg  [19:0] ctl_order,     // Controller order body
	output reg         ctl_exec,      // Controller order pulse
	output reg         bg_diag,       // Background diagnostic pulse
	output reg  [3:0]  audit_seg,     // Audit segment number
	output reg         audit_run,     // Audit segment pulse
	output reg         svc_req,       // Handler request level
	output reg  [1:0]  svc_op,        // Handler operation
	output reg  [3:0]  svc_link,      // Link being served
	input  wire        svc_ack,       // Handler finished pulse
	input  wire        svc_pass,      // Handler result
	input  wire [15:0] svc_data,      // Diagnostic data bytes
	input  wire [15:0] tx_room,       // Send queue fits a frame
	input  wire [15:0] dest_ready,    // Destination has data
	output reg         frame_send,    // Send one frame pulse
	input  wire        rx_frame_ok,   // Error-free frame received
	input  wire [2:0]  rx_type,       // Received frame type
	output reg         reply_send,    // Reply frame pulse
	output reg  [2:0]  reply_type,    // Reply frame type
	input  wire        sync_point     // Lossless switch point
);

	localparam S_INIT = 4'h0, S_UNLOAD = 4'h1, S_LINKS = 4'h2;
	localparam S_LWAIT = 4'h3, S_CHECK = 4'h4, S_MAINT = 4'h5;
	localparam S_MWAIT = 4'h6, S_HALT = 4'h7, S_RECOV = 4'h8;

	// Byte-lane merge for register writes
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					wmerge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	reg  [23:0]   mem [0:DEPTH-1];   // Input queue storage
	reg  [AW-1:0] wp_q, rp_q;        // Queue pointers
	reg  [AW:0]   cnt_q;             // Queue fill
	reg  [7:0]    param [0:255];     // Parameter table
	reg  [7:0]    load_ptr [0:15];   // Output buffer load pointers
	reg  [3:0]    st_q;              // Scheduler state
	reg  [TW-1:0] tmr_q;             // Cycle timer
	reg  [TW-1:0] seg_tmr_q;         // Diagnostic segment timer
	reg  [15:0]   cyc_q;             // Cycle counter
	reg           run_q;             // Scheduler enable
	reg           done_q, fault_q;   // Cycle done, overrun seen
	reg           recov_q;           // Next cycle is recovery
	reg  [15:0]   unload_q;          // Cumulative unload count
	reg  [15:0]   perr_q, merr_q;    // Parity and message errors
	reg  [3:0]    ecode_q;           // Last error code
	reg  [15:0]   active_q;          // Link active flags
	reg  [15:0]   restored_q, impasse_q; // Handshake outcome
	reg  [17:0]   diag_q;            // Valid, pass, data
	reg  [7:0]    pidx_q;            // Parameter read index
	reg  [3:0]    scan_q;            // Resume point of link scan
	reg  [4:0]    nsc_q;             // Links examined this cycle
	reg           pflag_q;           // Parameter since last pass
	reg           lowp_q;            // Stored low priority order
	reg  [19:0]   lowo_q;
	reg           def_q;             // Deferred application order
	reg  [3:0]    deft_q, defl_q;
	reg           sw_q;              // Soft switch pending
	reg  [3:0]    swl_q;
	reg           msg_q;             // Data message open
	reg  [7:0]    mexp_q, mcnt_q;    // Expected and seen words
	reg           aw_h, w_h;         // Write halves held
	reg  [7:0]    awa_q;
	reg  [31:0]   wd_q;
	reg  [3:0]    ws_q;

	wire          empty   = (cnt_q == {(AW+1){1'b0}});
	wire          expire  = (tmr_q == CYCLE_CLKS - 1);
	wire [31:0]   rem     = CYCLE_CLKS - {{(32-TW){1'b0}}, tmr_q};
	wire [23:0]   head    = mem[rp_q];
	wire          pop     = (st_q == S_UNLOAD) && !empty
	                        && (tmr_q < UNLOAD_CLKS) && !expire;
	wire          push    = in_valid && in_ready;
	wire          wdo     = aw_h && w_h && !s_axi_bvalid;
	wire          wok     = (awa_q[1:0] == 2'b00) && (awa_q <= `OFF_PDATA);
	wire          rd      = s_axi_arvalid && s_axi_arready;
	wire [3:0]    nxt_seg = (audit_seg == NSEG - 1) ? 4'h0 : audit_seg + 4'h1;
	wire [31:0]   act_m   = wmerge({16'h0, active_q}, wd_q, ws_q); // ACTIVE

	assign in_ready      = (cnt_q != DEPTH);
	assign s_axi_awready = !aw_h && !s_axi_bvalid;
	assign s_axi_wready  = !w_h && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Queue write side; check bit replaces parity on entry
	always @(posedge aclk) begin
		if (push)
			mem[wp_q] <= {^in_word, in_word[22:0]}; // RULE_01 RULE_24 RULE_02
	end

	// Queue pointers and fill level
	always @(posedge aclk) begin
		if (!aresetn) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Bus write channel; address and data may come in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_h <= 1'b0;
			w_h  <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_h  <= 1'b1;
				awa_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_h  <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wdo) begin
				aw_h <= 1'b0;
				w_h  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wok ? 2'b00 : 2'b10;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Bus read channel; one cycle to answer, unmapped gives SLVERR
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'b00;
		end else if (rd) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr[7:0])
			`OFF_CTRL:     s_axi_rdata <= {31'h0, run_q};
			`OFF_STATUS:   s_axi_rdata <= {cyc_q, 12'h0, sw_q,
			                               recov_q, fault_q, done_q};
			`OFF_UNLOAD:   s_axi_rdata <= {16'h0, unload_q};
			`OFF_ERRCNT:   s_axi_rdata <= {merr_q, perr_q};
			`OFF_ACTIVE:   s_axi_rdata <= {16'h0, active_q};
			`OFF_LINKSTAT: s_axi_rdata <= {impasse_q, restored_q};
			`OFF_DIAG:     s_axi_rdata <= {14'h0, diag_q};
			`OFF_ERRCODE:  s_axi_rdata <= {28'h0, ecode_q};
			`OFF_PIDX:     s_axi_rdata <= {24'h0, pidx_q};
			`OFF_PDATA:    s_axi_rdata <= {16'h0, load_ptr[pidx_q[3:0]],
			                               param[pidx_q]};
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Parameter table, written from the input queue only
	always @(posedge aclk) begin
		if (pop && head[`B_CHECK] && head[`B_MAINT] && head[`B_APP]
		    && head[19:16] == `MT_PARAM)
			param[head[15:8]] <= head[7:0]; // RULE_10
	end

	// Load pointers advance on each clean frame of the served link
	always @(posedge aclk) begin : lp
		integer i;
		if (!aresetn) begin
			for (i = 0; i < 16; i = i + 1)
				load_ptr[i] <= 8'h00;
		end else if (st_q == S_LWAIT && rx_frame_ok)
			load_ptr[svc_link] <= load_ptr[svc_link] + 8'h01; // RULE_19
	end

	// Cycle timer: free running, wraps every cycle period
	always @(posedge aclk) begin
		if (!aresetn)
			tmr_q <= {TW{1'b0}};
		else if (expire)
			tmr_q <= {TW{1'b0}}; // RULE_05
		else
			tmr_q <= tmr_q + 1'b1;
	end

	// Scheduler, sorter and link service
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_HALT;
			cyc_q <= 16'h0;
			run_q <= `CTRL_RST;
			done_q <= 1'b0;
			fault_q <= 1'b0;
			recov_q <= 1'b0;
			unload_q <= 16'h0;
			perr_q <= 16'h0;
			merr_q <= 16'h0;
			ecode_q <= 4'h0;
			active_q <= `ACTIVE_RST;
			restored_q <= 16'h0;
			impasse_q <= 16'h0;
			diag_q <= 18'h0;
			pidx_q <= 8'h00;
			scan_q <= 4'h0;
			nsc_q <= 5'h0;
			pflag_q <= 1'b0;
			lowp_q <= 1'b0;
			lowo_q <= 20'h0;
			def_q <= 1'b0;
			deft_q <= 4'h0;
			defl_q <= 4'h0;
			sw_q <= 1'b0;
			swl_q <= 4'h0;
			msg_q <= 1'b0;
			mexp_q <= 8'h00;
			mcnt_q <= 8'h00;
			seg_tmr_q <= {TW{1'b0}};
			data_payload <= 16'h0;
			data_dest <= 8'h00;
			data_valid <= 1'b0;
			msg_discard <= 1'b0;
			ctl_order <= 20'h0;
			ctl_exec <= 1'b0;
			bg_diag <= 1'b0;
			audit_seg <= 4'h0;
			audit_run <= 1'b0;
			svc_req <= 1'b0;
			svc_op <= `OP_COMM;
			svc_link <= 4'h0;
			frame_send <= 1'b0;
			reply_send <= 1'b0;
			reply_type <= 3'h0;
		end else begin
			// Pulses last one cycle
			data_valid <= 1'b0;
			msg_discard <= 1'b0;
			ctl_exec <= 1'b0;
			bg_diag <= 1'b0;
			audit_run <= 1'b0;
			frame_send <= 1'b0;
			reply_send <= 1'b0;
			// Software writes; hardware updates below take precedence
			if (wdo && wok) begin
				case (awa_q)
				`OFF_CTRL:
					if (ws_q[0])
						run_q <= wd_q[0];
				`OFF_STATUS:
					if (ws_q[0] && wd_q[1])
						fault_q <= 1'b0;
				`OFF_ACTIVE:
					active_q <= act_m[15:0];
				`OFF_PIDX:
					if (ws_q[0])
						pidx_q <= wd_q[7:0];
				default: ;
				endcase
			end
			// Word sorting while unloading
			if (pop) begin
				unload_q <= unload_q + 16'h1; // RULE_08
				if (!head[`B_CHECK]) begin
					perr_q <= perr_q + 16'h1; // RULE_03
					ecode_q <= `E_PARITY;
				end else if (!head[`B_MAINT]) begin // RULE_04
					if (head[22:16] != 7'h0) begin
						// Heading: close previous message first
						if (msg_q && mcnt_q != mexp_q) begin
							msg_discard <= 1'b1; // RULE_25
							merr_q <= merr_q + 16'h1;
							ecode_q <= `E_COUNT;
						end
						msg_q <= 1'b1;
						data_dest <= head[15:8];
						mexp_q <= head[7:0];
						mcnt_q <= 8'h01;
					end else if (msg_q) begin
						mcnt_q <= mcnt_q + 8'h01;
						data_payload <= head[15:0];
						data_valid <= 1'b1;
					end else begin
						merr_q <= merr_q + 16'h1;
						ecode_q <= `E_ORPHAN;
					end
				end else begin
					if (msg_q && mcnt_q != mexp_q) begin
						msg_discard <= 1'b1; // RULE_25
						merr_q <= merr_q + 16'h1;
						ecode_q <= `E_COUNT;
					end
					msg_q <= 1'b0;
					if (!head[`B_APP]) begin // RULE_23
						if (head[`B_PRIO]) begin
							ctl_order <= head[19:0];
							ctl_exec <= 1'b1; // RULE_09
						end else begin
							lowp_q <= 1'b1; // RULE_09
							lowo_q <= head[19:0];
						end
					end else case (head[19:16])
					`MT_PARAM: begin
						pflag_q <= 1'b1; // RULE_10
						audit_seg <= 4'h0;
					end
					`MT_SWITCH: begin
						sw_q <= 1'b1; // RULE_21
						swl_q <= head[3:0];
					end
					`MT_ACTIVATE, `MT_DIAG:
						if (def_q)
							ecode_q <= `E_BUSY;
						else begin
							def_q <= 1'b1;
							deft_q <= head[19:16];
							defl_q <= head[3:0];
						end
					default: ;
					endcase
				end
			end
			// Sequence of one cycle
			case (st_q)
			S_INIT: begin
				cyc_q <= cyc_q + 16'h1; // RULE_26
				done_q <= 1'b0;
				nsc_q <= 5'h0;
				st_q <= recov_q ? S_RECOV : S_UNLOAD; // RULE_06
			end
			S_UNLOAD:
				if (empty || tmr_q >= UNLOAD_CLKS)
					st_q <= S_LINKS; // RULE_07
			S_LINKS:
				if (nsc_q == NLINK || rem < LINK_CLKS)
					st_q <= S_CHECK; // RULE_11
				else if (active_q[scan_q]) begin
					svc_req <= 1'b1;
					svc_op <= `OP_COMM;
					svc_link <= scan_q;
					frame_send <= tx_room[scan_q]
					              && dest_ready[scan_q]; // RULE_17
					st_q <= S_LWAIT;
				end else begin
					scan_q <= scan_q + 4'h1; // RULE_12
					nsc_q <= nsc_q + 5'h1;
				end
			S_LWAIT: begin
				if (rx_frame_ok && rx_type != `RNR_TYPE) begin
					reply_send <= 1'b1; // RULE_18
					reply_type <= rx_type;
				end
				if (sw_q && sync_point && swl_q == svc_link) begin
					active_q[svc_link] <= 1'b0; // RULE_21
					active_q[svc_link ^ 4'h1] <= 1'b1;
					sw_q <= 1'b0;
				end
				if (svc_ack) begin
					svc_req <= 1'b0;
					scan_q <= scan_q + 4'h1; // RULE_12
					nsc_q <= nsc_q + 5'h1;
					st_q <= S_LINKS;
				end
			end
			S_CHECK:
				st_q <= (rem < MAINT_CLKS) ? S_HALT : S_MAINT; // RULE_13
			S_MAINT: begin
				st_q <= S_HALT;
				done_q <= 1'b1; // RULE_16
				if (!cyc_q[0]) begin // RULE_14
					if (lowp_q) begin
						lowp_q <= 1'b0;
						ctl_order <= lowo_q;
						ctl_exec <= 1'b1;
					end else
						bg_diag <= 1'b1;
				end else if (!pflag_q && def_q) begin // RULE_15
					def_q <= 1'b0;
					if (deft_q == `MT_DIAG && active_q[defl_q]) begin
						ecode_q <= `E_DIAGACT; // RULE_22
					end else begin
						svc_req <= 1'b1;
						svc_link <= defl_q;
						svc_op <= (deft_q == `MT_DIAG) ? `OP_DIAG
						                             : `OP_HSHAKE; // RULE_20
						seg_tmr_q <= {TW{1'b0}};
						done_q <= 1'b0;
						st_q <= S_MWAIT;
					end
				end else begin
					audit_run <= 1'b1; // RULE_15
					audit_seg <= nxt_seg;
					if (audit_seg == NSEG - 1)
						pflag_q <= 1'b0;
				end
			end
			S_MWAIT: begin
				seg_tmr_q <= seg_tmr_q + 1'b1;
				if (svc_ack || (svc_op == `OP_DIAG
				    && seg_tmr_q >= DIAG_CLKS - 1)) begin // RULE_22
					svc_req <= 1'b0;
					done_q <= 1'b1; // RULE_16
					st_q <= S_HALT;
					if (svc_op == `OP_DIAG)
						diag_q <= {1'b1, svc_ack && svc_pass,
						           svc_ack ? svc_data : 16'h0};
					else if (svc_pass) begin
						restored_q[svc_link] <= 1'b1; // RULE_20
						impasse_q[svc_link] <= 1'b0;
					end else begin
						impasse_q[svc_link] <= 1'b1; // RULE_20
						restored_q[svc_link] <= 1'b0;
						ecode_q <= `E_IMPASSE;
					end
				end
			end
			S_RECOV: begin
				// Audits only, one segment per clock until the current pass ends
				audit_run <= 1'b1;
				audit_seg <= nxt_seg;
				if (audit_seg == NSEG - 1) begin
					pflag_q <= 1'b0;
					recov_q <= 1'b0;
					done_q <= 1'b1;
					st_q <= S_HALT;
				end
			end
			S_HALT: ;
			default: st_q <= S_HALT;
			endcase
			// Timer expiry restarts the cycle; overrun is a fault
			if (expire) begin
				svc_req <= 1'b0;
				st_q <= run_q ? S_INIT : S_HALT; // RULE_05
				if (st_q != S_HALT) begin
					fault_q <= 1'b1; // RULE_06
					recov_q <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== logic/dlcs_map.vh ====
`ifndef DLCS_MAP_VH
`define DLCS_MAP_VH

// Register byte offsets on the AXI4-Lite bus
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_UNLOAD    8'h08
`define OFF_ERRCNT    8'h0c
`define OFF_ACTIVE    8'h10
`define OFF_LINKSTAT  8'h14
`define OFF_DIAG      8'h18
`define OFF_ERRCODE   8'h1c
`define OFF_PIDX      8'h20
`define OFF_PDATA     8'h24

// Reset values
`define CTRL_RST      1'b1
`define ACTIVE_RST    16'h0000

// Input word fields
`define B_CHECK       23
`define B_APP         22
`define B_PRIO        21
`define B_MAINT       20
`define F_MTYPE_HI    19
`define F_MTYPE_LO    16

// Application order types
`define MT_PARAM      4'h1
`define MT_ACTIVATE   4'h2
`define MT_DIAG       4'h3
`define MT_SWITCH     4'h4

// Error codes
`define E_PARITY      4'h1
`define E_COUNT       4'h2
`define E_ORPHAN      4'h3
`define E_BUSY        4'h4
`define E_DIAGACT     4'h5
`define E_IMPASSE     4'h6

// Times in milliseconds, clock rate in kHz
`define CLK_KHZ       25000
`define CYCLE_MS      20
`define UNLOAD_MS     10
`define LINK_MIN_MS   5
`define MAINT_MIN_MS  3
`define DIAG_MAX_MS   3

// Handler operations
`define OP_COMM       2'h0
`define OP_HSHAKE     2'h1
`define OP_DIAG       2'h2

// Reply frame type that is never produced
`define RNR_TYPE      3'h7

`endif

// ==== testbench/dlcs_properties.sv ====
`include "dlcs_map.vh"
`default_nettype none
module dlcs_properties (
	input wire logic        aclk,          // Clock
	input wire logic        aresetn,       // Reset, active low
	input wire logic        s_axi_awvalid, // Write address valid
	input wire logic        s_axi_awready, // Write address ready
	input wire logic        s_axi_wvalid,  // Write data valid
	input wire logic        s_axi_wready,  // Write data ready
	input wire logic        s_axi_bvalid,  // Write response valid
	input wire logic        in_ready,      // Queue has room
	input wire logic        svc_req,       // Handler request
	input wire logic [1:0]  svc_op,        // Handler operation
	input wire logic [3:0]  svc_link,      // Link served
	input wire logic        svc_ack,       // Handler done
	input wire logic [15:0] tx_room,       // Send room per link
	input wire logic [15:0] dest_ready,    // Data ready per link
	input wire logic        frame_send,    // Frame pulse
	input wire logic        rx_frame_ok,   // Frame received
	input wire logic [2:0]  rx_type,       // Received type
	input wire logic        reply_send,    // Reply pulse
	input wire logic [2:0]  reply_type     // Reply type
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write halves taken at one edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// A good frame arrives while a link is served
	sequence s_frame_in;
		svc_req && svc_op == `OP_COMM && rx_frame_ok && rx_type != `RNR_TYPE;
	endsequence
	a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
		else $error("write response missing");
	a_reply_follows: assert property (
		s_frame_in |=> reply_send && reply_type == $past(rx_type))
		else $error("reply frame missing or wrong type");
	a_reply_never_rnr: assert property (
		reply_send |-> reply_type != `RNR_TYPE)
		else $error("receiver not ready reply produced");
	a_reply_caused: assert property (
		reply_send |-> $past(rx_frame_ok))
		else $error("reply without a received frame");
	a_frame_gated: assert property (
		frame_send |-> svc_req && svc_op == `OP_COMM &&
		tx_room[svc_link] && dest_ready[svc_link])
		else $error("frame sent without room or data");
	a_req_steady: assert property (
		svc_req && $past(svc_req) |-> $stable(svc_link) && $stable(svc_op))
		else $error("handler request changed mid service");
	a_ack_ends_req: assert property (
		svc_req && svc_ack |=> !svc_req)
		else $error("request held after handler done");
	// Queue is empty, so it takes words, right after reset
	a_ready_at_reset: assert property (
		$past(!aresetn) |-> in_ready)
		else $error("queue refuses words after reset");
endmodule
bind data_link_controller_scheduler dlcs_properties chk_u (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .in_ready, .svc_req, .svc_op, .svc_link, .svc_ack,
	.tx_room, .dest_ready, .frame_send, .rx_frame_ok, .rx_type,
	.reply_send, .reply_type);
`default_nettype wire

// ==== testbench/link_handler_model.sv ====
`default_nettype none
module link_handler_model (
	input  wire logic        aclk,        // Clock
	input  wire logic        svc_req,     // Handler request level
	input  wire logic        hang,        // Withhold the answer
	output var  logic        svc_ack,     // Handler done pulse
	output var  logic        svc_pass,    // Result
	output var  logic [15:0] svc_data,    // Two result bytes
	output var  logic        rx_frame_ok, // Frame received pulse
	output var  logic [2:0]  rx_type      // Received frame type
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;  // Cycles into the current request
	bit slow = 0; // Alternates prompt and slow answers
	initial begin
		svc_ack = 1'b0;
		svc_pass = 1'b0;
		svc_data = 16'h0000;
		rx_frame_ok = 1'b0;
		rx_type = 3'h0;
	end
	// Answer each request once; idle lines keep changing
	always @(posedge aclk) begin
		svc_ack <= 1'b0;
		rx_frame_ok <= 1'b0;
		rx_type <= rx_type + 3'h1; // Walks through all types
		svc_data <= ~svc_data;     // Meaningless outside ack
		if (!svc_req || svc_ack) begin
			cnt <= 0;
		end else if (!hang) begin
			cnt <= cnt + 1;
			if (cnt == 1)
				rx_frame_ok <= 1'b1;
			if (cnt == (slow ? 30 : 3)) begin
				svc_ack <= 1'b1;
				svc_pass <= slow;
				slow <= !slow;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`include "dlcs_map.vh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CYC = 2000; // Shortened cycle in clocks
	logic aclk = 1'b0;
	logic aresetn;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, audit_seg, svc_link;
	logic [1:0]  s_axi_bresp, s_axi_rresp, svc_op;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, in_valid, in_ready;
	logic [23:0] in_word;
	logic [15:0] data_payload, svc_data, tx_room, dest_ready, lp;
	logic [7:0]  data_dest;
	logic [19:0] ctl_order, lo;
	logic        data_valid, msg_discard, ctl_exec, bg_diag, audit_run;
	logic        svc_req, svc_ack, svc_pass, frame_send, rx_frame_ok;
	logic        reply_send, sync_point, hang, svq;
	logic [2:0]  rx_type, reply_type;
	logic [31:0] rv, sv;     // Read data, saved read
	logic [1:0]  rr;         // Read response
	int fails = 0, num_checks = 0, nd = 0, nc = 0, nsvc = 0, nfr = 0;
	int n0, f0;              // Counter snapshots
	data_link_controller_scheduler #(.CYCLE_CLKS(CYC), .UNLOAD_CLKS(1000),
		.LINK_CLKS(500), .MAINT_CLKS(300), .DIAG_CLKS(300)) dut_u (.*);
	link_handler_model hnd_u (.*);
	always #20 aclk = ~aclk;
	// Count what the design emits
	always @(posedge aclk) begin
		svq <= svc_req;
		if (svc_req && !svq)
			nsvc <= nsvc + 1;
		if (frame_send)
			nfr <= nfr + 1;
		if (data_valid) begin
			nd <= nd + 1;
			lp <= data_payload;
		end
		if (ctl_exec) begin
			nc <= nc + 1;
			lo <= ctl_order;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// A bound that ran out ends the run
	task automatic tmo(input int n);
		if (n >= 60) begin
			fails++;
			finish_test();
		end
	endtask
	// Halves are released one by one as each is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		bit ta = 0, tw = 0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw) && n < 60) begin
			@(posedge aclk);
			n++;
			if (s_axi_awready && !ta) begin
				ta = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !tw) begin
				tw = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_bvalid && n < 60);
		s_axi_bready <= 1'b0;
		tmo(n);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n = 0;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 60);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_rvalid && n < 60);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(n);
		@(posedge aclk);
	endtask
	// Word is held until the queue takes it
	task automatic push(input logic [23:0] w);
		int n = 0;
		in_word <= w;
		in_valid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!in_ready && n < 60);
		in_valid <= 1'b0;
		in_word <= ~w;
		tmo(n);
		@(posedge aclk);
	endtask
	function automatic logic [23:0] good(input logic [22:0] w);
		return {~^w, w};
	endfunction
	initial begin
		{aresetn, in_valid, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, hang} = 4'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		in_word = 24'h000000;
		s_axi_wstrb = 4'hf;
		tx_room = 16'hffff;
		dest_ready = 16'hfffd;   // Link 1 has nothing to send
		sync_point = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`OFF_CTRL);
		chk(rv, 32'h1);
		rd(`OFF_ACTIVE);
		chk(rv, 32'h0);
		rd(8'h40);
		chk(rr, 2'b10);
		chk(rv, 32'h0);
		wr(`OFF_ACTIVE, 32'h3);
		rd(`OFF_ACTIVE);
		chk(rv, 32'h3);
		push(good(23'h01_0502));           // Heading, dest 5, 2 words
		push(good(23'h00_abcd));
		push(good(23'h30_0012));           // High priority order
		push(good(23'h00_1111) ^ 24'h80_0000);
		repeat (2 * CYC) @(posedge aclk);
		chk(nd, 1);
		chk(lp, 16'habcd);
		chk(lo, 20'h00012);
		rd(`OFF_UNLOAD);
		chk(rv, 32'h4);
		rd(`OFF_ERRCNT);
		chk(rv, 32'h1);
		rd(`OFF_ERRCODE);
		chk(rv, `E_PARITY);
		push(good(23'h01_0603));           // Count claims three words
		push(good(23'h00_0001));
		push(good(23'h10_0034));           // Low priority order
		repeat (2 * CYC + 200) @(posedge aclk);
		rd(`OFF_ERRCNT);
		chk(rv, 32'h0001_0001);
		chk(nc, 2);
		chk(lo, 20'h00034);
		rd(`OFF_STATUS);
		sv = rv;
		repeat (CYC) @(posedge aclk);
		rd(`OFF_STATUS);
		chk({16'h0, rv[31:16] - sv[31:16]}, 32'h1);
		chk(rv[0], 1'b1);
		n0 = nsvc;
		f0 = nfr;
		repeat (2 * CYC) @(posedge aclk);
		chk(nsvc - n0, 4);
		chk(nfr - f0, 2);
		hang <= 1'b1;                      // Handler stops answering
		repeat (2 * CYC) @(posedge aclk);
		hang <= 1'b0;
		rd(`OFF_STATUS);
		chk(rv[1], 1'b1);
		wr(`OFF_STATUS, 32'h2);
		rd(`OFF_STATUS);
		chk(rv[1], 1'b0);
		push(good(23'h52_0002));           // Activate link 2, deferred
		repeat (2 * CYC) @(posedge aclk);
		rd(`OFF_LINKSTAT);
		chk(rv[2] ^ rv[18], 1'b1);
		finish_test();
	end
	// Guard against a hang anywhere in the run
	initial begin
		repeat (60000) @(posedge aclk);
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire
